// *** logic/ptm_pkg.sv ***
// constants shared by the dual programmable timer
package ptm_pkg;
  localparam int CNT_W = 8;
  localparam int NIB_W = 4;
  localparam int ADR_W = 16;

  // i/o word addresses
  localparam logic [15:0] ADR_MODE    = 16'hffc0;
  localparam logic [15:0] ADR_SRC     = 16'hffc1;
  localparam logic [15:0] ADR_CTL0    = 16'hffc2;
  localparam logic [15:0] ADR_CTL1    = 16'hffc3;
  localparam logic [15:0] ADR_RLD0_LO = 16'hffc4;
  localparam logic [15:0] ADR_RLD0_HI = 16'hffc5;
  localparam logic [15:0] ADR_RLD1_LO = 16'hffc6;
  localparam logic [15:0] ADR_RLD1_HI = 16'hffc7;
  localparam logic [15:0] ADR_CNT0_LO = 16'hffc8;
  localparam logic [15:0] ADR_CNT0_HI = 16'hffc9;
  localparam logic [15:0] ADR_CNT1_LO = 16'hffca;
  localparam logic [15:0] ADR_CNT1_HI = 16'hffcb;
  localparam logic [15:0] ADR_IRQ_EN  = 16'hffe2;
  localparam logic [15:0] ADR_IRQ_FLG = 16'hfff2;

  // mode word fields
  localparam int MODE_CHAIN = 3;
  localparam int MODE_EVENT_COUNT_SELECT = 2;
  localparam int MODE_FILT  = 1;
  localparam int MODE_POL   = 0;
  // source word fields
  localparam int SRC_PULSE_OUT_CHANNEL_SELECT  = 3;
  localparam int SRC_POUT   = 2;
  localparam int SRC_CH1    = 1;
  localparam int SRC_CH0    = 0;
  // channel control word fields
  localparam int CTL_RATIO_LO = 2;
  localparam int CTL_RATIO_HI = 3;
  localparam int CTL_STROBE   = 1;
  localparam int CTL_RUN      = 0;

  localparam logic [3:0] NIB_RST  = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // prescaler ratio codes and divisors
  localparam logic [1:0] RATIO_1   = 2'h0;
  localparam logic [1:0] RATIO_4   = 2'h1;
  localparam logic [1:0] RATIO_32  = 2'h2;
  localparam logic [1:0] RATIO_256 = 2'h3;
  localparam int DIV_1   = 1;
  localparam int DIV_4   = 4;
  localparam int DIV_32  = 32;
  localparam int DIV_256 = 256;

  // falling edges of the 2048 hz signal before a level is accepted
  localparam logic [1:0] FILT_EDGES = 2'h2;
endpackage

// *** logic/ptm_presc_if.sv ***
// carrier between the timer core and one channel prescaler
interface ptm_presc_if;
  logic       src_tick;
  logic       run;
  logic       clr;
  logic [1:0] ratio;
  logic       out_tick;
  modport core  (output src_tick, output run, output clr, output ratio, input out_tick);
  modport presc (input src_tick, input run, input clr, input ratio, output out_tick);
endinterface

// *** logic/ptm_prescaler.sv ***
// one channel prescaler: divides source ticks by 1, 4, 32 or 256
module ptm_prescaler
  import ptm_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic    sys_clk,
  input wire logic    rst,
  input wire logic    ce,
  ptm_presc_if.presc  pif
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] lim;
  logic             tick_q;

  always_comb begin
    case (pif.ratio)
      RATIO_4:   lim = DIV_W'(DIV_4 - 1);
      RATIO_32:  lim = DIV_W'(DIV_32 - 1);
      RATIO_256: lim = DIV_W'(DIV_256 - 1);
      default:   lim = DIV_W'(DIV_1 - 1);
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (!pif.run || pif.clr) begin
        div_q <= '0;
      end else if (pif.src_tick) begin
        if (div_q >= lim) begin
          div_q  <= '0;
          tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 1'b1;
        end
      end
    end
  end

  assign pif.out_tick = tick_q;
endmodule

// *** logic/ptm_timer_top.sv ***
// dual 8-bit programmable down timer with 4-bit i/o register window
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - channel 0 prescaler uses slow tick when select bit 0, fast when 1
// - channel 1 has own source select bit, next bit in same word
// - event counting makes channel 0 ignore its source select
// - ratio code 3/2/1/0 divides by 256/32/4/1; resets to 0
// - event counting makes channel 0 ignore its ratio field
// - channel 0 mode bit: 1 event counting, 0 periodic timer
// - width bit: 1 chains both channels into one 16-bit timer
// - per-channel run bit: 1 counts down, 0 stops; resets to 0; when chained, channel 1 ignores its own run bit and follows channel 0
// - channel 0 reload value as low and high nibble words
// - channel 1 reload value as low and high nibble words
// - channel 0 count readable as read-only nibbles, zero after reset
// - channel 1 count readable as read-only nibbles
// - flag reads 1 after interrupt; write 1 clears; write 0 ignored
// - reload strobe copies reload value into counter; strobe reads 0
// - event edge: falling when polarity 0, rising when polarity 1
// - filter accepts level change at second 2048 hz falling edge
// - reading low count nibble latches high nibble; read low first
////////////////////////////////////////////////////////////////////////////////
module ptm_timer_top
  import ptm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] io_addr,
  input  wire logic [3:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [3:0]  io_rdata,
  input  wire logic        slow_oscillator,
  input  wire logic        fast_oscillator,
  input  wire logic        sig_2048hz,
  input  wire logic        event_input_pin,
  output logic      [1:0]  irq_req
);
  logic [3:0]       mode_q;
  logic [3:0]       src_q;
  logic [1:0]       ratio_q [2];
  logic [1:0]       run_q;
  logic [CNT_W-1:0] reld_q [2];
  logic [CNT_W-1:0] cnt_q [2];
  logic [NIB_W-1:0] hold_q [2];
  logic [1:0]       mask_q;
  logic [1:0]       flag_q;
  logic [3:0]       rdata_q;
  logic [1:0]       irq_q;
  logic             ev_q;
  logic             filt_lvl_q;
  logic [1:0]       fcnt_q;
  logic             lvl_prev_q;
  logic             s2k_prev_q;

  logic             chain;
  logic             evmode;
  logic [1:0]       strobe;
  logic             fall2k;
  logic             lvl;
  logic             ev_tick;
  logic             clk0;
  logic             dec0;
  logic             dec1;
  logic             z0;
  logic             z1;
  logic             load0;
  logic [1:0]       uf_set;
  logic [1:0]       flg_clr;
  logic [3:0]       rmux;

  ptm_presc_if pif0 ();
  ptm_presc_if pif1 ();

  assign chain  = mode_q[MODE_CHAIN];
  assign evmode = mode_q[MODE_EVENT_COUNT_SELECT];

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  assign strobe[0] = io_wr && io_addr == ADR_CTL0 && io_wdata[CTL_STROBE];
  assign strobe[1] = io_wr && io_addr == ADR_CTL1 && io_wdata[CTL_STROBE];
  assign flg_clr   = (io_wr && io_addr == ADR_IRQ_FLG) ? io_wdata[1:0] : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q     <= NIB_RST;
      src_q      <= NIB_RST;
      ratio_q[0] <= RATIO_1;
      ratio_q[1] <= RATIO_1;
      run_q      <= 2'h0;
      mask_q     <= 2'h0;
    end else if (ce && io_wr) begin
      case (io_addr)
        ADR_MODE:   mode_q <= io_wdata;
        ADR_SRC:    src_q <= io_wdata;
        ADR_CTL0: begin
          ratio_q[0] <= io_wdata[CTL_RATIO_HI:CTL_RATIO_LO];
          run_q[0]   <= io_wdata[CTL_RUN];
        end
        ADR_CTL1: begin
          ratio_q[1] <= io_wdata[CTL_RATIO_HI:CTL_RATIO_LO];
          run_q[1]   <= io_wdata[CTL_RUN];
        end
        ADR_IRQ_EN: mask_q <= io_wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reld_q[0] <= BYTE_RST;
      reld_q[1] <= BYTE_RST;
    end else if (ce && io_wr) begin
      case (io_addr)
        ADR_RLD0_LO: reld_q[0][3:0] <= io_wdata;
        ADR_RLD0_HI: reld_q[0][7:4] <= io_wdata;
        ADR_RLD1_LO: reld_q[1][3:0] <= io_wdata;
        ADR_RLD1_HI: reld_q[1][7:4] <= io_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external event input with optional noise filter
  assign fall2k = s2k_prev_q && !sig_2048hz;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ev_q       <= 1'b0;
      filt_lvl_q <= 1'b0;
      fcnt_q     <= 2'h0;
      lvl_prev_q <= 1'b0;
      s2k_prev_q <= 1'b0;
    end else if (ce) begin
      ev_q       <= event_input_pin;
      s2k_prev_q <= sig_2048hz;
      lvl_prev_q <= lvl;
      // a change shorter than two 2048 hz falls never reaches the counter
      if (ev_q == filt_lvl_q) begin
        fcnt_q <= 2'h0;
      end else if (fall2k) begin
        if (fcnt_q == FILT_EDGES - 2'h1) begin
          filt_lvl_q <= ev_q;
          fcnt_q     <= 2'h0;
        end else begin
          fcnt_q <= fcnt_q + 2'h1;
        end
      end
    end
  end

  assign lvl     = mode_q[MODE_FILT] ? filt_lvl_q : ev_q;
  assign ev_tick = mode_q[MODE_POL] ? (lvl && !lvl_prev_q)
                                    : (!lvl && lvl_prev_q);

  ////////////////////////////////////////////////////////////////////////////////
  // prescalers and count clocks
  assign pif0.src_tick = src_q[SRC_CH0] ? fast_oscillator : slow_oscillator;
  assign pif1.src_tick = src_q[SRC_CH1] ? fast_oscillator : slow_oscillator;
  assign pif0.ratio    = ratio_q[0];
  assign pif1.ratio    = ratio_q[1];
  assign pif0.run      = run_q[0];
  assign pif1.run      = run_q[1];
  assign pif0.clr      = strobe[0];
  assign pif1.clr      = strobe[1];

  ptm_prescaler #(.DIV_W(CNT_W)) u_presc0 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pif     (pif0)
  );
  ptm_prescaler #(.DIV_W(CNT_W)) u_presc1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .pif     (pif1)
  );

  // event mode bypasses the prescaler, so its source and ratio do nothing
  assign clk0  = evmode ? ev_tick : pif0.out_tick;
  assign z0    = cnt_q[0] == BYTE_RST;
  assign z1    = cnt_q[1] == BYTE_RST;
  assign dec0  = run_q[0] && clk0;
  assign dec1  = chain ? (dec0 && z0) : (run_q[1] && pif1.out_tick);
  assign load0 = dec0 && z0 && (!chain || z1);
  assign uf_set[0] = dec0 && z0 && !chain;
  assign uf_set[1] = dec1 && z1;

  ////////////////////////////////////////////////////////////////////////////////
  // down counters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q[0] <= BYTE_RST;
      cnt_q[1] <= BYTE_RST;
    end else if (ce) begin
      if (strobe[0] || load0) begin
        cnt_q[0] <= reld_q[0];
      end else if (dec0 && z0) begin
        cnt_q[0] <= BYTE_MAX;
      end else if (dec0) begin
        cnt_q[0] <= cnt_q[0] - 8'h01;
      end
      if (strobe[1] || (dec1 && z1)) begin
        cnt_q[1] <= reld_q[1];
      end else if (dec1) begin
        cnt_q[1] <= cnt_q[1] - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags and interrupt requests
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag_q <= 2'h0;
      irq_q  <= 2'h0;
    end else if (ce) begin
      // a new underflow beats a clear in the same cycle
      flag_q <= (flag_q & ~flg_clr) | uf_set;
      irq_q  <= flag_q & mask_q;
    end
  end

  assign irq_req = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read path, answer one cycle after io_rd
  always_comb begin
    case (io_addr)
      ADR_MODE:    rmux = mode_q;
      ADR_SRC:     rmux = src_q;
      ADR_CTL0:    rmux = {ratio_q[0], 1'b0, run_q[0]};
      ADR_CTL1:    rmux = {ratio_q[1], 1'b0, run_q[1]};
      ADR_RLD0_LO: rmux = reld_q[0][3:0];
      ADR_RLD0_HI: rmux = reld_q[0][7:4];
      ADR_RLD1_LO: rmux = reld_q[1][3:0];
      ADR_RLD1_HI: rmux = reld_q[1][7:4];
      ADR_CNT0_LO: rmux = cnt_q[0][3:0];
      ADR_CNT0_HI: rmux = hold_q[0];
      ADR_CNT1_LO: rmux = cnt_q[1][3:0];
      ADR_CNT1_HI: rmux = hold_q[1];
      ADR_IRQ_EN:  rmux = {2'h0, mask_q};
      ADR_IRQ_FLG: rmux = {2'h0, flag_q};
      default:     rmux = NIB_RST;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q   <= NIB_RST;
      hold_q[0] <= NIB_RST;
      hold_q[1] <= NIB_RST;
    end else if (ce && io_rd) begin
      rdata_q <= rmux;
      // high nibble frozen so a carry between the two reads cannot tear
      if (io_addr == ADR_CNT0_LO) hold_q[0] <= cnt_q[0][7:4];
      if (io_addr == ADR_CNT1_LO) hold_q[1] <= cnt_q[1][7:4];
    end
  end

  assign io_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_flag_on_uf: assert property (ce && uf_set[0] |=> flag_q[0])
    else $error("underflow did not set flag 0");
  a_flag_clear: assert property (ce && flg_clr[1] && !uf_set[1] |=> !flag_q[1])
    else $error("write one did not clear flag 1");
  a_flag_hold: assert property (ce && flag_q[0] && !flg_clr[0] |=> flag_q[0])
    else $error("flag 0 dropped without a clear");
  a_irq_gate: assert property (ce && flag_q[1] && !mask_q[1] |=> !irq_req[1])
    else $error("masked interrupt requested");
  a_irq_follow: assert property (ce && flag_q[0] && mask_q[0] |=> irq_req[0])
    else $error("unmasked flag gave no request");
  a_strobe_load: assert property (ce && strobe[1] |=> cnt_q[1] == $past(reld_q[1]))
    else $error("strobe did not load counter 1");
  a_stop_holds: assert property (ce && !run_q[0] && !strobe[0] |=> $stable(cnt_q[0]))
    else $error("stopped counter 0 moved");
  a_uf_reload: assert property (ce && dec1 && z1 && !strobe[1]
                                |=> cnt_q[1] == $past(reld_q[1]))
    else $error("underflow did not reload counter 1");
  a_chain_noflag: assert property (ce && chain && !flag_q[0] |=> !flag_q[0])
    else $error("chained mode set flag 0");
  a_event_bypass: assert property (ce && evmode && !ev_tick && !strobe[0]
                                   |=> $stable(cnt_q[0]))
    else $error("prescaler clocked channel 0 in event mode");
  a_ctl_readzero: assert property (ce && io_rd && io_addr == ADR_CTL0
                                   |=> !io_rdata[CTL_STROBE])
    else $error("reload strobe read back as one");
  a_high_latch: assert property (ce && io_rd && io_addr == ADR_CNT0_LO
                                 |=> hold_q[0] == $past(cnt_q[0][7:4]))
    else $error("high count nibble not latched");
  a_filter_wait: assert property (ce && !fall2k |=> $stable(filt_lvl_q))
    else $error("filtered level moved without a 2048 hz fall");

  c_uf_ch0:   cover property (ce && uf_set[0]);
  c_chain_uf: cover property (ce && chain && uf_set[1]);
  c_event:    cover property (ce && evmode && dec0);
  c_set_clr:  cover property (ce && uf_set[0] && flg_clr[0]);
endmodule

// *** bench/ptm_timer_top_tb_top.sv ***
// self-checking bench for the dual programmable timer register window
module ptm_timer_top_tb_top
  import ptm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk;
  logic        rst;
  logic        ce;
  logic [15:0] io_addr;
  logic [3:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic [3:0]  io_rdata;
  logic        slow_oscillator;
  logic        fast_oscillator;
  logic        sig_2048hz;
  logic        event_input_pin;
  logic [1:0]  irq_req;
  int          n_fail;
  int          n_tests;

  ptm_timer_top ptm_timer_top_i (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .ce              (ce),
    .io_addr         (io_addr),
    .io_wdata        (io_wdata),
    .io_wr           (io_wr),
    .io_rd           (io_rd),
    .io_rdata        (io_rdata),
    .slow_oscillator (slow_oscillator),
    .fast_oscillator (fast_oscillator),
    .sig_2048hz      (sig_2048hz),
    .event_input_pin (event_input_pin),
    .irq_req         (irq_req)
  );

  initial begin
    sys_clk = 1'b0; rst = 1'b1; ce = 1'b1; io_addr = 16'h0000; io_wdata = 4'h0;
    io_wr = 1'b0; io_rd = 1'b0; slow_oscillator = 1'b0; fast_oscillator = 1'b0;
    sig_2048hz = 1'b0; event_input_pin = 1'b0; n_fail = 0; n_tests = 0;
  end
  always #20 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge sys_clk) begin
      io_addr <= a; io_wdata <= d; io_wr <= 1'b1;
    end
    @(posedge sys_clk) io_wr <= 1'b0;
  endtask

  // rdata lands at the edge that takes the strobe, so sample just after it
  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge sys_clk) begin
      io_addr <= a; io_rd <= 1'b1;
    end
    @(posedge sys_clk) io_rd <= 1'b0;
    #1 d = io_rdata;
  endtask

  // low nibble first so the high nibble comes from the same snapshot
  task automatic rd8(input logic [15:0] a, output logic [7:0] v);
    rd(a, v[3:0]);
    rd(a + 16'h0001, v[7:4]);
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] v);
    wr(a, v[3:0]);
    wr(a + 16'h0001, v[7:4]);
  endtask

  task automatic chk8(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd8(a, v);
    chk(v, exp);
  endtask

  task automatic chk4(input logic [15:0] a, input logic [3:0] exp);
    logic [3:0] d;
    rd(a, d);
    chk({4'h0, d}, {4'h0, exp});
  endtask

  // source ticks are single-cycle pulses; three idle edges let the count land
  task automatic tick(input bit fast, input int n);
    repeat (n) begin
      @(posedge sys_clk) if (fast) fast_oscillator <= 1'b1; else slow_oscillator <= 1'b1;
      @(posedge sys_clk) begin
        fast_oscillator <= 1'b0; slow_oscillator <= 1'b0;
      end
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic ev(input logic lvl);
    @(posedge sys_clk) event_input_pin <= lvl;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic fall_2048();
    @(posedge sys_clk) sig_2048hz <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sig_2048hz <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] adr [15] = '{ADR_MODE, ADR_SRC, ADR_CTL0, ADR_CTL1, ADR_RLD0_LO,
      ADR_RLD0_HI, ADR_RLD1_LO, ADR_RLD1_HI, ADR_CNT0_LO, ADR_CNT0_HI, ADR_CNT1_LO,
      ADR_CNT1_HI, ADR_IRQ_EN, ADR_IRQ_FLG, 16'hffcc};
    do_reset();
    foreach (adr[i]) chk4(adr[i], 4'h0);
    chk({6'h00, irq_req}, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_regs();
    do_reset();
    wr(ADR_MODE, 4'hf);
    chk4(ADR_MODE, 4'hf);
    wr(ADR_SRC, 4'hf);
    chk4(ADR_SRC, 4'hf);
    wr(ADR_CTL1, 4'hf);
    chk4(ADR_CTL1, 4'hd);
    wr8(ADR_RLD0_LO, 8'ha5);
    wr8(ADR_RLD1_LO, 8'h3c);
    chk8(ADR_RLD0_LO, 8'ha5);
    chk8(ADR_RLD1_LO, 8'h3c);
    wr(ADR_CNT0_LO, 4'hf);
    wr(ADR_CNT1_HI, 4'hf);
    // the reload words reach the counter only through a strobe or an underflow
    wr(ADR_CTL1, 4'h2);
    chk8(ADR_CNT0_LO, 8'h00);
    chk8(ADR_CNT1_LO, 8'h3c);
    wr(ADR_IRQ_EN, 4'hf);
    chk4(ADR_IRQ_EN, 4'h3);
    $display("test register access done");
  endtask

  task automatic t_under();
    logic [3:0] d;
    do_reset();
    wr8(ADR_RLD0_LO, 8'h01);
    wr(ADR_CTL0, 4'h3);
    tick(1'b0, 1);
    chk8(ADR_CNT0_LO, 8'h00);
    tick(1'b0, 1);
    chk8(ADR_CNT0_LO, 8'h01);
    chk4(ADR_IRQ_FLG, 4'h1);
    chk({6'h00, irq_req}, 8'h00);
    wr(ADR_IRQ_FLG, 4'h0);
    chk4(ADR_IRQ_FLG, 4'h1);
    wr(ADR_IRQ_FLG, 4'h1);
    chk4(ADR_IRQ_FLG, 4'h0);
    wr(ADR_IRQ_EN, 4'h1);
    tick(1'b0, 2);
    chk({6'h00, irq_req}, 8'h01);
    rd(ADR_IRQ_FLG, d);
    chk({4'h0, d}, 8'h01);
    $display("test underflow and flags done");
  endtask

  task automatic t_ratio();
    int div [4] = '{DIV_1, DIV_4, DIV_32, DIV_256};
    do_reset();
    wr8(ADR_RLD0_LO, 8'h10);
    wr(ADR_CTL0, 4'h3);
    tick(1'b1, 2);
    chk8(ADR_CNT0_LO, 8'h10);
    for (int i = 0; i < 4; i++) begin
      wr(ADR_CTL0, {i[1:0], 2'b11});
      tick(1'b0, div[i] - 1);
      chk8(ADR_CNT0_LO, 8'h10);
      tick(1'b0, 1);
      chk8(ADR_CNT0_LO, 8'h0f);
    end
    wr(ADR_SRC, 4'h2);
    wr8(ADR_RLD1_LO, 8'h05);
    wr(ADR_CTL1, 4'h7);
    tick(1'b0, 4);
    chk8(ADR_CNT1_LO, 8'h05);
    tick(1'b1, 4);
    chk8(ADR_CNT1_LO, 8'h04);
    $display("test prescaler ratios done");
  endtask

  task automatic t_event();
    do_reset();
    wr(ADR_SRC, 4'h1);
    wr8(ADR_RLD0_LO, 8'h10);
    wr(ADR_CTL0, 4'h3);
    wr(ADR_MODE, 4'h4);
    tick(1'b1, 2);
    tick(1'b0, 2);
    chk8(ADR_CNT0_LO, 8'h10);
    ev(1'b1);
    chk8(ADR_CNT0_LO, 8'h10);
    ev(1'b0);
    chk8(ADR_CNT0_LO, 8'h0f);
    wr(ADR_MODE, 4'h5);
    ev(1'b1);
    chk8(ADR_CNT0_LO, 8'h0e);
    ev(1'b0);
    chk8(ADR_CNT0_LO, 8'h0e);
    // filter delays acceptance, so a level change alone must not count
    wr(ADR_MODE, 4'h7);
    ev(1'b1);
    chk8(ADR_CNT0_LO, 8'h0e);
    fall_2048();
    chk8(ADR_CNT0_LO, 8'h0e);
    fall_2048();
    chk8(ADR_CNT0_LO, 8'h0d);
    $display("test event counting done");
  endtask

  task automatic t_chain();
    do_reset();
    wr(ADR_MODE, 4'h8);
    wr(ADR_IRQ_EN, 4'h3);
    wr8(ADR_RLD1_LO, 8'h01);
    wr(ADR_CTL1, 4'h2);
    wr(ADR_CTL0, 4'h3);
    tick(1'b0, 1);
    chk8(ADR_CNT0_LO, 8'hff);
    chk8(ADR_CNT1_LO, 8'h00);
    tick(1'b0, 255);
    chk8(ADR_CNT0_LO, 8'h00);
    chk4(ADR_IRQ_FLG, 4'h0);
    tick(1'b0, 1);
    chk4(ADR_IRQ_FLG, 4'h2);
    chk8(ADR_CNT1_LO, 8'h01);
    chk({6'h00, irq_req}, 8'h02);
    // masking drops the request but leaves the flag standing
    wr(ADR_IRQ_EN, 4'h1);
    chk4(ADR_IRQ_FLG, 4'h2);
    chk({6'h00, irq_req}, 8'h00);
    wr(ADR_IRQ_FLG, 4'h2);
    chk4(ADR_IRQ_FLG, 4'h0);
    $display("test chained mode done");
  endtask

  task automatic t_latch();
    logic [3:0] d;
    do_reset();
    wr8(ADR_RLD0_LO, 8'h10);
    wr(ADR_CTL0, 4'h3);
    rd(ADR_CNT0_LO, d);
    chk({4'h0, d}, 8'h00);
    tick(1'b0, 1);
    rd(ADR_CNT0_HI, d);
    chk({4'h0, d}, 8'h01);
    chk8(ADR_CNT0_LO, 8'h0f);
    $display("test count snapshot done");
  endtask

  // with the clock enable low, neither ticks nor writes may touch any state
  task automatic t_hold();
    do_reset();
    wr8(ADR_RLD0_LO, 8'h10);
    wr(ADR_CTL0, 4'h3);
    @(posedge sys_clk) ce <= 1'b0;
    tick(1'b0, 2);
    wr(ADR_IRQ_EN, 4'h3);
    @(posedge sys_clk) ce <= 1'b1;
    chk8(ADR_CNT0_LO, 8'h10);
    chk4(ADR_IRQ_EN, 4'h0);
    tick(1'b0, 1);
    chk8(ADR_CNT0_LO, 8'h0f);
    $display("test clock enable done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // the whole run needs under two thousand cycles; allow ample margin
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    t_reset();
    t_regs();
    t_under();
    t_ratio();
    t_event();
    t_chain();
    t_latch();
    t_hold();
    final_report();
  end
endmodule
